// file: l1c_top.sv
// Purpose: level-one instruction and data caches with line locking
// Assumes: core and memory interface logic run on clock; requests carry both addresses
// Notes: blocking caches, one request in flight each
// Functional notes
// - instruction cache holds sixteen kilobytes
// - instruction index taken from virtual address
// - tag: 22 physical bits, valid, lock
// - instruction lru ages kept in separate array
// - line fill buffer gathers refill words
// - fetch served by buffer bypass, array hit or memory
// - instruction lines locked per entry by op
// - data cache holds four kilobytes
// - data cache virtually indexed, physically tagged
// - per-set array holds dirty and lru bits
// - store hit on locked line updates it
// - locked lines never chosen as victim
// - data lines locked per entry by op
// - geometry readable through configuration words
`timescale 1ns/10ps
`default_nettype none
module l1c_cache
#(
  parameter int SETS = l1c_pkg::IC_SETS,
  parameter bit IS_DATA = 1'b0
)
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_we,
  input wire logic req_op,
  input wire logic req_lock,
  input wire logic [l1c_pkg::ADDR_W-1:0] req_vaddr,
  input wire logic [l1c_pkg::ADDR_W-1:0] req_paddr,
  input wire logic [l1c_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [l1c_pkg::DATA_W-1:0] rsp_data,
  output logic mem_req,
  output logic mem_we,
  output logic [l1c_pkg::ADDR_W-1:0] mem_addr,
  output logic [l1c_pkg::DATA_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [l1c_pkg::DATA_W-1:0] mem_rdata
);
  import l1c_pkg::*;
  localparam int IDX_W = $clog2(SETS);

  // storage arrays; lru ages and dirty bits live apart from the tags
  logic [TAG_W-1:0] tag_a [WAYS][SETS];
  logic [WAYS-1:0] val_a [SETS];
  logic [WAYS-1:0] lck_a [SETS];
  logic [DATA_W-1:0] dat_a [SETS][WAYS][LINE_WORDS];
  logic [META_W-1:0] meta_a [SETS];

  l1c_state_e st_r, st_nxt;
  logic we_r, we_nxt, op_r, op_nxt, lock_r, lock_nxt;
  logic [ADDR_W-1:0] vaddr_r, vaddr_nxt, paddr_r, paddr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [WAY_W-1:0] way_r, way_nxt;
  logic [BEAT_W-1:0] beat_r, beat_nxt;
  logic alloc_r, alloc_nxt, single_r, single_nxt;
  logic [DATA_W-1:0] lfb_r [LINE_WORDS];
  logic [DATA_W-1:0] lfb_nxt [LINE_WORDS];
  logic [ADDR_W-OFF_W-1:0] lfb_line_r, lfb_line_nxt;
  logic lfb_val_r, lfb_val_nxt;
  logic ready_r, ready_nxt, rsp_v_r, rsp_v_nxt;
  logic [DATA_W-1:0] rsp_d_r, rsp_d_nxt;
  logic mreq_r, mreq_nxt, mwe_r, mwe_nxt;
  logic [ADDR_W-1:0] maddr_r, maddr_nxt;
  logic [DATA_W-1:0] mwd_r, mwd_nxt;

  logic [IDX_W-1:0] idx;
  logic [BEAT_W-1:0] wsel;
  logic [TAG_W-1:0] ptag;
  logic hit, lfb_hit;
  logic [WAY_W-1:0] hw;
  logic line_we, word_we, lock_we, meta_we;
  logic [META_W-1:0] meta_new;
  logic [DATA_W-1:0] line_new [LINE_WORDS];

  l1c_vict_if vif();
  l1c_victim u_victim (.vif(vif.pick));

  assign req_ready = ready_r;
  assign rsp_valid = rsp_v_r;
  assign rsp_data = rsp_d_r;
  assign mem_req = mreq_r;
  assign mem_we = mwe_r;
  assign mem_addr = maddr_r;
  assign mem_wdata = mwd_r;

  // move a way to most recent, ageing the younger ones; dirty bits untouched
  function automatic logic [META_W-1:0] lru_touch(input logic [META_W-1:0] m, input logic [WAY_W-1:0] w);
    logic [AGE_W-1:0] a;
    logic [META_W-1:0] r;
    r = m;
    a = m[w*AGE_W+:AGE_W];
    for (int i = 0; i < WAYS; i++)
    begin
      if (m[i*AGE_W+:AGE_W] < a)
        r[i*AGE_W+:AGE_W] = m[i*AGE_W+:AGE_W] + 1'b1;
    end
    r[w*AGE_W+:AGE_W] = '0;
    return r;
  endfunction : lru_touch

  // index from the virtual address while the tag compares the physical one
  always_comb
  begin
    idx = vaddr_r[OFF_W+:IDX_W];
    wsel = vaddr_r[WORD_LSB+:BEAT_W];
    ptag = paddr_r[ADDR_W-1:TAG_LSB];
    hit = 1'b0;
    hw = '0;
    for (int w = 0; w < WAYS; w++)
    begin
      if (val_a[idx][w] && tag_a[w][idx] == ptag)
      begin
        hit = 1'b1;
        hw = WAY_W'(w);
      end
    end
    lfb_hit = !IS_DATA && lfb_val_r && lfb_line_r == paddr_r[ADDR_W-1:OFF_W];
    vif.valid = val_a[idx];
    vif.lock = lck_a[idx];
    vif.age = meta_a[idx][WAYS*AGE_W-1:0];
    for (int k = 0; k < LINE_WORDS; k++)
      line_new[k] = (we_r && wsel == BEAT_W'(k)) ? wdata_r : lfb_r[k];
  end

  // request sequencing: lookup, optional write-back, refill, install
  always_comb
  begin
    st_nxt = st_r;
    we_nxt = we_r;
    op_nxt = op_r;
    lock_nxt = lock_r;
    vaddr_nxt = vaddr_r;
    paddr_nxt = paddr_r;
    wdata_nxt = wdata_r;
    way_nxt = way_r;
    beat_nxt = beat_r;
    alloc_nxt = alloc_r;
    single_nxt = single_r;
    lfb_nxt = lfb_r;
    lfb_line_nxt = lfb_line_r;
    lfb_val_nxt = lfb_val_r;
    ready_nxt = ready_r;
    rsp_v_nxt = 1'b0;
    rsp_d_nxt = rsp_d_r;
    mreq_nxt = mreq_r;
    mwe_nxt = mwe_r;
    maddr_nxt = maddr_r;
    mwd_nxt = mwd_r;
    line_we = 1'b0;
    word_we = 1'b0;
    lock_we = 1'b0;
    meta_we = 1'b0;
    meta_new = meta_a[idx];
    case (st_r)
      ST_IDLE:
      begin
        if (req_valid && ready_r)
        begin
          we_nxt = req_we && IS_DATA;
          op_nxt = req_op;
          lock_nxt = req_lock;
          vaddr_nxt = req_vaddr;
          paddr_nxt = req_paddr;
          wdata_nxt = req_wdata;
          ready_nxt = 1'b0;
          st_nxt = ST_LOOK;
        end
      end
      ST_LOOK:
      begin
        ready_nxt = 1'b1;
        st_nxt = ST_IDLE;
        rsp_v_nxt = 1'b1;
        if (op_r)
        begin
          lock_we = hit;
          rsp_d_nxt = '0;
        end
        else if (lfb_hit)
          rsp_d_nxt = lfb_r[wsel];
        else if (hit)
        begin
          // locked lines take stores like any other line
          word_we = we_r;
          meta_we = 1'b1;
          meta_new = lru_touch(meta_a[idx], hw);
          meta_new[WAYS*AGE_W + int'(hw)] = meta_a[idx][WAYS*AGE_W + int'(hw)] | we_r;
          rsp_d_nxt = we_r ? wdata_r : dat_a[idx][hw][wsel];
        end
        else
        begin
          rsp_v_nxt = 1'b0;
          ready_nxt = 1'b0;
          alloc_nxt = vif.found;
          way_nxt = vif.way;
          single_nxt = 1'b0;
          beat_nxt = '0;
          mreq_nxt = 1'b1;
          if (IS_DATA && vif.found && val_a[idx][vif.way] && meta_a[idx][WAYS*AGE_W + int'(vif.way)])
          begin
            // only the data cache gets here, where tag, index and offset span exactly 32 bits
            mwe_nxt = 1'b1;
            maddr_nxt = ADDR_W'({tag_a[vif.way][idx], idx, OFF_W'(0)});
            mwd_nxt = dat_a[idx][vif.way][0];
            st_nxt = ST_WB;
          end
          else if (we_r && !vif.found)
          begin
            // every way locked: the store goes straight to memory
            mwe_nxt = 1'b1;
            maddr_nxt = paddr_r;
            mwd_nxt = wdata_r;
            single_nxt = 1'b1;
            st_nxt = ST_WB;
          end
          else
          begin
            mwe_nxt = 1'b0;
            maddr_nxt = {paddr_r[ADDR_W-1:OFF_W], OFF_W'(0)};
            lfb_val_nxt = 1'b0;
            st_nxt = ST_FILL;
          end
        end
      end
      ST_WB:
      begin
        if (mem_ack && single_r)
        begin
          mreq_nxt = 1'b0;
          mwe_nxt = 1'b0;
          rsp_v_nxt = 1'b1;
          rsp_d_nxt = wdata_r;
          ready_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end
        else if (mem_ack && beat_r == LAST_BEAT)
        begin
          // victim is out; refill may now overwrite it
          mwe_nxt = 1'b0;
          beat_nxt = '0;
          maddr_nxt = {paddr_r[ADDR_W-1:OFF_W], OFF_W'(0)};
          lfb_val_nxt = 1'b0;
          st_nxt = ST_FILL;
        end
        else if (mem_ack)
        begin
          beat_nxt = beat_r + 1'b1;
          mwd_nxt = dat_a[idx][way_r][beat_r + 1'b1];
        end
      end
      ST_FILL:
      begin
        if (mem_ack)
        begin
          lfb_nxt[beat_r] = mem_rdata;
          // requested word is handed over the moment it arrives
          if (!we_r && beat_r == wsel)
          begin
            rsp_v_nxt = 1'b1;
            rsp_d_nxt = mem_rdata;
          end
          beat_nxt = beat_r + 1'b1;
          if (beat_r == LAST_BEAT)
          begin
            mreq_nxt = 1'b0;
            lfb_line_nxt = paddr_r[ADDR_W-1:OFF_W];
            st_nxt = ST_DONE;
          end
        end
      end
      ST_DONE:
      begin
        line_we = alloc_r;
        meta_we = alloc_r;
        meta_new = lru_touch(meta_a[idx], way_r);
        meta_new[WAYS*AGE_W + int'(way_r)] = we_r;
        lfb_val_nxt = !IS_DATA;
        rsp_v_nxt = we_r;
        rsp_d_nxt = wdata_r;
        ready_nxt = 1'b1;
        st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // valid, lock and per-set metadata need a known state after reset
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int s = 0; s < SETS; s++)
      begin
        val_a[s] <= '0;
        lck_a[s] <= '0;
        meta_a[s] <= META_RST;
      end
    end
    else
    begin
      if (line_we)
      begin
        val_a[idx][way_r] <= 1'b1;
        lck_a[idx][way_r] <= 1'b0;
      end
      if (lock_we)
        lck_a[idx][hw] <= lock_r;
      if (meta_we)
        meta_a[idx] <= meta_new;
    end
  end

  // tag and data arrays carry no reset; valid bits guard them
  always_ff @(posedge clock)
  begin
    if (line_we)
    begin
      tag_a[way_r][idx] <= ptag;
      for (int k = 0; k < LINE_WORDS; k++)
        dat_a[idx][way_r][k] <= line_new[k];
    end
    if (word_we)
      dat_a[idx][hw][wsel] <= wdata_r;
  end

  // control registers
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= ST_IDLE;
      we_r <= 1'b0;
      op_r <= 1'b0;
      lock_r <= 1'b0;
      vaddr_r <= '0;
      paddr_r <= '0;
      wdata_r <= '0;
      way_r <= '0;
      beat_r <= '0;
      alloc_r <= 1'b0;
      single_r <= 1'b0;
      for (int k = 0; k < LINE_WORDS; k++)
        lfb_r[k] <= '0;
      lfb_line_r <= '0;
      lfb_val_r <= 1'b0;
      ready_r <= 1'b1;
      rsp_v_r <= 1'b0;
      rsp_d_r <= '0;
      mreq_r <= 1'b0;
      mwe_r <= 1'b0;
      maddr_r <= '0;
      mwd_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      we_r <= we_nxt;
      op_r <= op_nxt;
      lock_r <= lock_nxt;
      vaddr_r <= vaddr_nxt;
      paddr_r <= paddr_nxt;
      wdata_r <= wdata_nxt;
      way_r <= way_nxt;
      beat_r <= beat_nxt;
      alloc_r <= alloc_nxt;
      single_r <= single_nxt;
      lfb_r <= lfb_nxt;
      lfb_line_r <= lfb_line_nxt;
      lfb_val_r <= lfb_val_nxt;
      ready_r <= ready_nxt;
      rsp_v_r <= rsp_v_nxt;
      rsp_d_r <= rsp_d_nxt;
      mreq_r <= mreq_nxt;
      mwe_r <= mwe_nxt;
      maddr_r <= maddr_nxt;
      mwd_r <= mwd_nxt;
    end
  end
endmodule : l1c_cache

module l1c_top
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ic_req_valid,
  input wire logic ic_req_op,
  input wire logic ic_req_lock,
  input wire logic [l1c_pkg::ADDR_W-1:0] ic_req_vaddr,
  input wire logic [l1c_pkg::ADDR_W-1:0] ic_req_paddr,
  output logic ic_req_ready,
  output logic ic_rsp_valid,
  output logic [l1c_pkg::DATA_W-1:0] ic_rsp_data,
  output logic ic_mem_req,
  output logic [l1c_pkg::ADDR_W-1:0] ic_mem_addr,
  input wire logic ic_mem_ack,
  input wire logic [l1c_pkg::DATA_W-1:0] ic_mem_rdata,
  input wire logic dc_req_valid,
  input wire logic dc_req_we,
  input wire logic dc_req_op,
  input wire logic dc_req_lock,
  input wire logic [l1c_pkg::ADDR_W-1:0] dc_req_vaddr,
  input wire logic [l1c_pkg::ADDR_W-1:0] dc_req_paddr,
  input wire logic [l1c_pkg::DATA_W-1:0] dc_req_wdata,
  output logic dc_req_ready,
  output logic dc_rsp_valid,
  output logic [l1c_pkg::DATA_W-1:0] dc_rsp_data,
  output logic dc_mem_req,
  output logic dc_mem_we,
  output logic [l1c_pkg::ADDR_W-1:0] dc_mem_addr,
  output logic [l1c_pkg::DATA_W-1:0] dc_mem_wdata,
  input wire logic dc_mem_ack,
  input wire logic [l1c_pkg::DATA_W-1:0] dc_mem_rdata,
  output logic [l1c_pkg::DATA_W-1:0] ic_cfg,
  output logic [l1c_pkg::DATA_W-1:0] dc_cfg
);
  import l1c_pkg::*;
  localparam l1c_word_t IC_CFG = l1c_cfg_word(IC_SETS, IC_KBYTES, 1'b0);
  localparam l1c_word_t DC_CFG = l1c_cfg_word(DC_SETS, DC_KBYTES, 1'b1);

  // geometry words, held in flops so the outputs are registered
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ic_cfg <= IC_CFG;
      dc_cfg <= DC_CFG;
    end
    else
    begin
      ic_cfg <= IC_CFG;
      dc_cfg <= DC_CFG;
    end
  end

  // instruction side never stores, so its write lines are unused
  l1c_cache #(.SETS(IC_SETS), .IS_DATA(1'b0)) u_icache (
    .clock(clock), .arst_n(arst_n), .req_valid(ic_req_valid), .req_we(1'b0),
    .req_op(ic_req_op), .req_lock(ic_req_lock), .req_vaddr(ic_req_vaddr),
    .req_paddr(ic_req_paddr), .req_wdata(32'h0), .req_ready(ic_req_ready),
    .rsp_valid(ic_rsp_valid), .rsp_data(ic_rsp_data), .mem_req(ic_mem_req),
    .mem_we(), .mem_addr(ic_mem_addr), .mem_wdata(), .mem_ack(ic_mem_ack),
    .mem_rdata(ic_mem_rdata));

  l1c_cache #(.SETS(DC_SETS), .IS_DATA(1'b1)) u_dcache (
    .clock(clock), .arst_n(arst_n), .req_valid(dc_req_valid), .req_we(dc_req_we),
    .req_op(dc_req_op), .req_lock(dc_req_lock), .req_vaddr(dc_req_vaddr),
    .req_paddr(dc_req_paddr), .req_wdata(dc_req_wdata), .req_ready(dc_req_ready),
    .rsp_valid(dc_rsp_valid), .rsp_data(dc_rsp_data), .mem_req(dc_mem_req),
    .mem_we(dc_mem_we), .mem_addr(dc_mem_addr), .mem_wdata(dc_mem_wdata),
    .mem_ack(dc_mem_ack), .mem_rdata(dc_mem_rdata));
endmodule : l1c_top
`default_nettype wire

// file: l1c_pkg.sv
// Purpose: shared constants and types for the level-one instruction and data caches
// Assumes: 32-bit physical addresses, 4-word lines, 4 ways per set
// Notes: the configuration word layout is what software reads back
package l1c_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int TAG_W = 22;
  localparam int TAG_LSB = 10;
  localparam int LINE_WORDS = 4;
  localparam int BEAT_W = 2;
  localparam int OFF_W = 4;
  localparam int WORD_LSB = 2;
  localparam int WAYS = 4;
  localparam int WAY_W = 2;
  localparam int AGE_W = 2;
  localparam int META_W = WAYS * (AGE_W + 1);
  localparam int IC_SETS = 256;
  localparam int DC_SETS = 64;
  localparam int IC_KBYTES = 16;
  localparam int DC_KBYTES = 4;
  // configuration word fields
  localparam int CFG_SETS_LSB = 0;
  localparam int CFG_LINE_LSB = 4;
  localparam int CFG_WAYS_LSB = 8;
  localparam int CFG_LOCK_BIT = 12;
  localparam int CFG_WB_BIT = 13;
  localparam int CFG_KB_LSB = 16;
  // ages 3,2,1,0 per way give a legal lru order, all lines clean
  localparam logic [META_W-1:0] META_RST = 12'h0E4;
  localparam logic [BEAT_W-1:0] LAST_BEAT = 2'h3;

  typedef enum {ST_IDLE, ST_LOOK, ST_WB, ST_FILL, ST_DONE} l1c_state_e;
  typedef logic [DATA_W-1:0] l1c_word_t;

  // geometry word for one cache
  function automatic l1c_word_t l1c_cfg_word(input int sets, input int kbytes, input logic wb);
    l1c_word_t r;
    r = '0;
    r[CFG_SETS_LSB+:4] = 4'($clog2(sets));
    r[CFG_LINE_LSB+:4] = 4'($clog2(LINE_WORDS * DATA_W / 8));
    r[CFG_WAYS_LSB+:4] = 4'(WAYS - 1);
    r[CFG_LOCK_BIT] = 1'b1;
    r[CFG_WB_BIT] = wb;
    r[CFG_KB_LSB+:8] = 8'(kbytes);
    return r;
  endfunction : l1c_cfg_word
endpackage : l1c_pkg

// file: l1c_vict_if.sv
// Purpose: carries one set's way state to the victim picker and its choice back
// Assumes: l1c_pkg compiled first
// Notes: purely combinational signals
`timescale 1ns/10ps
`default_nettype none
interface l1c_vict_if;
  import l1c_pkg::*;
  logic [WAYS-1:0] valid;
  logic [WAYS-1:0] lock;
  logic [WAYS*AGE_W-1:0] age;
  logic [WAY_W-1:0] way;
  logic found;
  modport ctrl (output valid, output lock, output age, input way, input found);
  modport pick (input valid, input lock, input age, output way, output found);
endinterface : l1c_vict_if
`default_nettype wire

// file: l1c_victim.sv
// Purpose: choose the replacement way of one set
// Assumes: ages form a permutation, largest is least recently used
// Notes: an empty way beats any valid way; found is low when all ways are locked
`timescale 1ns/10ps
`default_nettype none
module l1c_victim
(
  l1c_vict_if.pick vif
);
  import l1c_pkg::*;
  logic [AGE_W:0] best;
  logic [AGE_W:0] score;

  // locked ways never compete, so a fully locked set reports no victim
  always_comb
  begin
    best = '0;
    score = '0;
    vif.found = 1'b0;
    vif.way = '0;
    for (int i = 0; i < WAYS; i++)
    begin
      score = {~vif.valid[i], vif.age[i*AGE_W+:AGE_W]};
      if (!vif.lock[i] && (!vif.found || score > best))
      begin
        vif.found = 1'b1;
        vif.way = WAY_W'(i);
        best = score;
      end
    end
  end
endmodule : l1c_victim
`default_nettype wire

// file: l1c_props.sv
// Purpose: port-level checks of the cache pair
// Assumes: l1c_pkg compiled first
// Notes: helper flops hold the last taken request and count memory beats
`timescale 1ns/10ps
`default_nettype none
module l1c_props
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ic_req_valid,
  input wire logic ic_req_ready,
  input wire logic [l1c_pkg::ADDR_W-1:0] ic_req_paddr,
  input wire logic ic_rsp_valid,
  input wire logic ic_mem_req,
  input wire logic [l1c_pkg::ADDR_W-1:0] ic_mem_addr,
  input wire logic ic_mem_ack,
  input wire logic dc_req_valid,
  input wire logic dc_req_we,
  input wire logic dc_req_op,
  input wire logic [l1c_pkg::ADDR_W-1:0] dc_req_paddr,
  input wire logic [l1c_pkg::DATA_W-1:0] dc_req_wdata,
  input wire logic dc_req_ready,
  input wire logic dc_rsp_valid,
  input wire logic [l1c_pkg::DATA_W-1:0] dc_rsp_data,
  input wire logic dc_mem_req,
  input wire logic dc_mem_we,
  input wire logic [l1c_pkg::ADDR_W-1:0] dc_mem_addr,
  input wire logic dc_mem_ack,
  input wire logic [l1c_pkg::DATA_W-1:0] ic_cfg,
  input wire logic [l1c_pkg::DATA_W-1:0] dc_cfg
);
  import l1c_pkg::*;
  logic [ADDR_W-1:0] ipa_r;
  logic [ADDR_W-1:0] dpa_r;
  logic [DATA_W-1:0] dwd_r;
  logic dwe_r;
  logic dop_r;
  logic [2:0] ibt_r;
  logic [2:0] dwb_r;
  logic [2:0] drd_r;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // beat counters clear between bursts so a short burst cannot hide
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {ipa_r, dpa_r, dwd_r, dwe_r, dop_r} <= '0;
      {ibt_r, dwb_r, drd_r} <= '0;
    end
    else
    begin
      if (ic_req_valid && ic_req_ready)
        ipa_r <= ic_req_paddr;
      if (dc_req_valid && dc_req_ready)
        {dpa_r, dwd_r, dwe_r, dop_r} <= {dc_req_paddr, dc_req_wdata, dc_req_we, dc_req_op};
      ibt_r <= ic_mem_req ? ibt_r + 3'(ic_mem_ack) : 3'h0;
      dwb_r <= dc_mem_req ? dwb_r + 3'(dc_mem_ack && dc_mem_we) : 3'h0;
      drd_r <= dc_mem_req ? drd_r + 3'(dc_mem_ack && !dc_mem_we) : 3'h0;
    end
  end
  cfg_words_a: assert property (ic_cfg == 32'h0010_1348 && dc_cfg == 32'h0004_3346)
    else $error("configuration word wrong");
  ic_lookup_a: assert property (ic_req_valid && ic_req_ready |-> ##2 (ic_rsp_valid || ic_mem_req))
    else $error("fetch not answered in time");
  ic_fill_addr_a: assert property ($rose(ic_mem_req) |-> ic_mem_addr == {ipa_r[31:4], 4'h0})
    else $error("fetch refill address wrong");
  ic_fill_beats_a: assert property ($fell(ic_mem_req) |-> ibt_r == 3'h4)
    else $error("fetch refill beat count wrong");
  ic_mem_hold_a: assert property (ic_mem_req && !ic_mem_ack |=> ic_mem_req && $stable(ic_mem_addr))
    else $error("fetch request dropped");
  dc_fill_addr_a: assert property ($rose(dc_mem_req) && !dc_mem_we |-> dc_mem_addr == {dpa_r[31:4], 4'h0})
    else $error("data refill address wrong");
  dc_wb_fill_a: assert property (dc_mem_req && $fell(dc_mem_we) |-> dwb_r == 3'h4 && dc_mem_addr == {dpa_r[31:4], 4'h0})
    else $error("write-back not four beats");
  dc_burst_end_a: assert property ($fell(dc_mem_req) |-> drd_r == 3'h4 || dwb_r == 3'h1)
    else $error("data burst ended early");
  dc_store_echo_a: assert property (dc_rsp_valid && dwe_r && !dop_r |-> dc_rsp_data == dwd_r)
    else $error("store answer wrong");
  dc_op_zero_a: assert property (dc_rsp_valid && dop_r |-> dc_rsp_data == '0)
    else $error("lock op answer not zero");
  wb_seen_c: cover property (dc_mem_req && $fell(dc_mem_we));
  ic_fill_c: cover property ($rose(ic_mem_req));
  dc_op_c: cover property (dc_rsp_valid && dop_r);
endmodule : l1c_props

bind l1c_top l1c_props i_l1c_props (.clock, .arst_n, .ic_req_valid, .ic_req_ready, .ic_req_paddr, .ic_rsp_valid,
  .ic_mem_req, .ic_mem_addr, .ic_mem_ack, .dc_req_valid, .dc_req_we, .dc_req_op, .dc_req_paddr, .dc_req_wdata,
  .dc_req_ready, .dc_rsp_valid, .dc_rsp_data, .dc_mem_req, .dc_mem_we, .dc_mem_addr, .dc_mem_ack, .ic_cfg, .dc_cfg);
`default_nettype wire

// file: l1c_mem_model.sv
// Purpose: external memory behind one cache, one beat per acknowledged cycle
// Assumes: unwritten words read as a fixed function of their address
// Notes: slow mode stalls at random; idle read data flips so stale words never match
`timescale 1ns/10ps
`default_nettype none
module l1c_mem_model
(
  input wire logic clock,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [l1c_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [l1c_pkg::DATA_W-1:0] mem_wdata,
  output logic mem_ack,
  output logic [l1c_pkg::DATA_W-1:0] mem_rdata,
  output int bursts,
  output int wbeats
);
  import l1c_pkg::*;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] a;
  logic req_q = 1'b0;
  int beat = 0;
  int seed = 87279;
  initial
  begin
    {mem_ack, mem_rdata} = '0;
    bursts = 0;
    wbeats = 0;
  end
  // take the beat at the edge, then answer just after it
  always @(posedge clock)
  begin
    a = mem_addr + 32'(beat * 4);
    if (mem_req && mem_ack)
    begin
      if (mem_we)
        mem[a] = mem_wdata;
      wbeats += int'(mem_we);
      beat = (beat == 3) ? 0 : beat + 1;
    end
    #1;
    bursts += int'(mem_req && !req_q);
    req_q = mem_req;
    if (!mem_req)
      beat = 0;
    a = mem_addr + 32'(beat * 4);
    mem_ack = mem_req && (!slow || ($random(seed) & 1) == 0);
    mem_rdata = !mem_ack ? ~mem_rdata : mem.exists(a) ? mem[a] : a ^ 32'h5A5A_5A5A;
  end
endmodule : l1c_mem_model
`default_nettype wire

// file: testbench.sv
// Purpose: self-checking bench for the cache pair
// Assumes: two memory models stand behind the caches
// Notes: a monitor pairs each answer with the oldest queued note
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import l1c_pkg::*;
  logic clock, arst_n, slow;
  logic ic_req_valid, ic_req_op, ic_req_lock, ic_req_ready, ic_rsp_valid, ic_mem_req, ic_mem_ack;
  logic [ADDR_W-1:0] ic_req_vaddr, ic_req_paddr, ic_mem_addr, dc_req_vaddr, dc_req_paddr, dc_mem_addr;
  logic [DATA_W-1:0] ic_rsp_data, ic_mem_rdata, dc_req_wdata, dc_rsp_data, dc_mem_wdata, dc_mem_rdata, ic_cfg, dc_cfg;
  logic dc_req_valid, dc_req_we, dc_req_op, dc_req_lock, dc_req_ready, dc_rsp_valid, dc_mem_req, dc_mem_we, dc_mem_ack;
  logic [DATA_W-1:0] ic_q[$];
  logic [DATA_W-1:0] dc_q[$];
  logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] ib, db;
  int err_count = 0, checks_done = 0, seed = 87279, ic_bursts, dc_bursts, dc_wbeats, b0, w0;

  l1c_top i_l1c_top (.clock, .arst_n, .ic_req_valid, .ic_req_op, .ic_req_lock, .ic_req_vaddr, .ic_req_paddr,
    .ic_req_ready, .ic_rsp_valid, .ic_rsp_data, .ic_mem_req, .ic_mem_addr, .ic_mem_ack, .ic_mem_rdata,
    .dc_req_valid, .dc_req_we, .dc_req_op, .dc_req_lock, .dc_req_vaddr, .dc_req_paddr, .dc_req_wdata,
    .dc_req_ready, .dc_rsp_valid, .dc_rsp_data, .dc_mem_req, .dc_mem_we, .dc_mem_addr, .dc_mem_wdata,
    .dc_mem_ack, .dc_mem_rdata, .ic_cfg, .dc_cfg);
  l1c_mem_model i_l1c_mem_model_i (.clock, .slow, .mem_req(ic_mem_req), .mem_we(1'b0), .mem_addr(ic_mem_addr),
    .mem_wdata('0), .mem_ack(ic_mem_ack), .mem_rdata(ic_mem_rdata), .bursts(ic_bursts), .wbeats());
  l1c_mem_model i_l1c_mem_model_d (.clock, .slow, .mem_req(dc_mem_req), .mem_we(dc_mem_we), .mem_addr(dc_mem_addr),
    .mem_wdata(dc_mem_wdata), .mem_ack(dc_mem_ack), .mem_rdata(dc_mem_rdata), .bursts(dc_bursts), .wbeats(dc_wbeats));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // present one request and hold it until taken; valid stays up for the next caller
  task automatic req(input bit d, input logic we, input logic op, input logic lk, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] wd);
    int n;
    logic [DATA_W-1:0] e;
    n = 0;
    e = op ? '0 : we ? wd : (d && shadow.exists(a)) ? shadow[a] : a ^ 32'h5A5A_5A5A;
    if (d)
    begin
      {dc_req_valid, dc_req_we, dc_req_op, dc_req_lock, dc_req_paddr, dc_req_wdata} = {1'b1, we, op, lk, a, wd};
      dc_req_vaddr = a ^ 32'hC000_0000;
      if (we && !op)
        shadow[a] = wd;
      dc_q.push_back(e);
    end
    else
    begin
      {ic_req_valid, ic_req_op, ic_req_lock, ic_req_paddr} = {1'b1, op, lk, a};
      ic_req_vaddr = a ^ 32'hA000_0000;
      ic_q.push_back(e);
    end
    do
    begin
      @(negedge clock);
      n++;
    end
    while ((d ? dc_req_ready : ic_req_ready) !== 1'b1 && n < 200);
    err_count += int'(n == 200);
    @(posedge clock);
    #1;
  endtask : req

  // release both ports and wait until every noted answer came back
  task automatic drain;
    int n;
    n = 0;
    ic_req_valid = 1'b0;
    dc_req_valid = 1'b0;
    while ((ic_q.size() + dc_q.size() != 0 || ic_req_ready !== 1'b1 || dc_req_ready !== 1'b1) && n < 500)
    begin
      @(negedge clock);
      n++;
    end
    err_count += int'(n == 500);
    @(posedge clock);
    #1;
  endtask : drain

  // answers are one-cycle pulses, so look once per cycle at the falling edge
  always @(negedge clock)
  begin
    if (ic_rsp_valid === 1'b1)
      check(ic_rsp_data, ic_q.size() ? ic_q.pop_front() : ~ic_rsp_data, "ic_rsp_data");
    if (dc_rsp_valid === 1'b1)
      check(dc_rsp_data, dc_q.size() ? dc_q.pop_front() : ~dc_rsp_data, "dc_rsp_data");
  end

  initial
  begin
    #300000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    {ic_req_valid, ic_req_op, ic_req_lock, ic_req_vaddr, ic_req_paddr} = '0;
    {dc_req_valid, dc_req_we, dc_req_op, dc_req_lock, dc_req_vaddr, dc_req_paddr, dc_req_wdata} = '0;
    {arst_n, slow} = 2'b00;
    repeat (20) @(posedge clock);
    #1 arst_n = 1'b1;
    check(ic_cfg, 32'h0010_1348, "ic_cfg");
    check(dc_cfg, 32'h0004_3346, "dc_cfg");
    // fetch a whole line: one refill, later words from buffer
    ib = $random(seed) & 32'hFFFF_FFF0;
    b0 = ic_bursts;
    for (int w = 0; w < 4; w++)
      req(0, 0, 0, 0, ib + 32'(4 * w), '0);
    drain();
    check(32'(ic_bursts - b0), 32'h1, "ic_line_refills");
    // a locked line survives four misses in its set, an unlocked one does not
    req(0, 0, 1, 1, ib, '0);
    for (int k = 1; k < 5; k++)
      req(0, 0, 0, 0, ib + 32'(k * 4096), '0);
    req(0, 0, 0, 0, ib + 32'h8, '0);
    req(0, 0, 1, 0, ib, '0);
    for (int k = 5; k < 9; k++)
      req(0, 0, 0, 0, ib + 32'(k * 4096), '0);
    req(0, 0, 0, 0, ib + 32'hC, '0);
    drain();
    check(32'(ic_bursts - b0), 32'hA, "ic_lock_refills");
    // data side, stalling memory: allocate, lock, store on locked line, evict dirty lines
    slow = 1'b1;
    db = $random(seed) & 32'hFFFF_FFF0;
    b0 = dc_bursts;
    w0 = dc_wbeats;
    req(1, 1, 0, 0, db + 32'h4, $random(seed));
    req(1, 0, 0, 0, db + 32'h4, '0);
    req(1, 0, 0, 0, db, '0);
    req(1, 0, 1, 1, db, '0);
    req(1, 0, 1, 1, db ^ 32'h40, '0);
    req(1, 1, 0, 0, db + 32'h8, $random(seed));
    req(1, 0, 0, 0, db + 32'h8, '0);
    for (int k = 1; k < 5; k++)
      req(1, 1, 0, 0, db + 32'(k * 1024), $random(seed));
    req(1, 0, 0, 0, db + 32'h8, '0);
    req(1, 0, 0, 0, db + 32'h400, '0);
    drain();
    check(32'(dc_bursts - b0), 32'h6, "dc_refills");
    check(32'(dc_wbeats - w0), 32'h8, "dc_writeback_beats");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
